// ==== inc/paof_consts.svh ====
// Constants for the port alternate function override block
`ifndef PAOF_CONSTS_SVH
`define PAOF_CONSTS_SVH

// ==========================================================================
// Port geometry
`define PAOF_PIN_COUNT      6
`define PAOF_PIN0           0
`define PAOF_PIN1           1
`define PAOF_PIN2           2
`define PAOF_PIN3           3
`define PAOF_PIN4           4
`define PAOF_PIN5           5

// ==========================================================================
// Fuse encoding: a programmed fuse reads as this level
`define PAOF_FUSE_PROGRAMMED 1'h0

// ==========================================================================
// Reset value of the top pin mode register
`define PAOF_PIN5_MODE_RST  paof_pkg::PAOF_PIN5_RESET_INPUT

`endif

// ==== inc/paof_pkg.sv ====
// Types shared by the port alternate function override block
package paof_pkg;

	// ======================================================================
	// Role of the top pin, chosen from the fuses
	typedef enum logic [1:0] {
		PAOF_PIN5_RESET_INPUT,
		PAOF_PIN5_DEBUG_LINK,
		PAOF_PIN5_GENERAL_IO
	} paof_pin5_mode_t;

endpackage

// ==== hdl/paof_port_override.sv ====
// Alternate function override and pad control for the six-bit port
`timescale 1ns/1ps
`include "paof_consts.svh"

module paof_port_override #(
	parameter int PIN_COUNT = `PAOF_PIN_COUNT	// Pins in the port
) (
	input  wire logic                 clk,                            // System clock
	input  wire logic                 rst_n,                          // Async reset, low
	input  wire logic [PIN_COUNT-1:0] port_value,                     // Port output value bits
	input  wire logic [PIN_COUNT-1:0] port_dir,                       // Port direction bits
	input  wire logic                 pullup_disable,                 // Global pull-up disable
	input  wire logic                 sleep_input_disable,            // Sleep gates inputs
	input  wire logic                 reset_disable_fuse,             // Low when programmed
	input  wire logic                 debug_link_enable_fuse,         // Low when programmed
	input  wire logic                 lock_bits_unprogrammed,         // Locks all open
	input  wire logic                 clock_output_fuse,              // Low when programmed
	input  wire logic                 divided_clock_out,              // Divided system clock
	input  wire logic                 debug_link_transmit_low,        // Debug link pulls low
	input  wire logic                 oscillator_output_pin_used,     // Pin 4 is oscillator
	input  wire logic                 oscillator_input_pin_used,      // Pin 3 is oscillator
	input  wire logic                 spi_enable,                     // SPI active
	input  wire logic                 spi_master,                     // SPI is master
	input  wire logic                 three_wire_mode_active,         // Three-wire serial
	input  wire logic                 three_wire_serial_out,          // Serial data out
	input  wire logic                 two_wire_mode_active,           // Two-wire serial
	input  wire logic                 two_wire_clock_hold,            // Hold clock low
	input  wire logic                 two_wire_data_out,              // Data line release
	input  wire logic                 two_wire_clock_toggle,          // Toggle clock port bit
	input  wire logic                 analog_reference_pin,           // Pin 0 is reference
	input  wire logic                 timer0_compare_a_en,            // Compare A drives pin 0
	input  wire logic                 timer0_compare_a_out,           // Compare A waveform
	input  wire logic                 timer0_compare_b_en,            // Compare B drives pin 1
	input  wire logic                 timer0_compare_b_out,           // Compare B waveform
	input  wire logic                 timer1_compare_a_en,            // Timer1 A on pins 1, 0
	input  wire logic                 timer1_compare_a_out,           // Timer1 A waveform
	input  wire logic                 timer1_compare_b_en,            // Timer1 B on pins 4, 3
	input  wire logic                 timer1_compare_b_out,           // Timer1 B waveform
	input  wire logic [PIN_COUNT-1:0] pin_change_mask,                // Per-pin change mask
	input  wire logic                 pin_change_enable,              // Pin change enable
	input  wire logic                 analog_ch0_digital_disable,     // Pin 5 analog
	input  wire logic                 analog_ch1_digital_disable,     // Pin 2 analog
	input  wire logic                 analog_ch2_digital_disable,     // Pin 4 analog
	input  wire logic                 analog_ch3_digital_disable,     // Pin 3 analog
	input  wire logic                 comparator_neg_digital_disable, // Pin 1 analog
	input  wire logic                 comparator_pos_digital_disable, // Pin 0 analog
	input  wire logic                 serial_start_interrupt_enable,  // Start detector on
	output logic      [PIN_COUNT-1:0] pad_pullup_en,                  // Pull-up per pad
	output logic      [PIN_COUNT-1:0] pad_out,                        // Driven value per pad
	output logic      [PIN_COUNT-1:0] pad_oe,                         // Driver enable per pad
	output logic      [PIN_COUNT-1:0] pad_input_en,                   // Input path enable
	output logic      [PIN_COUNT-1:0] port_toggle_request,            // Invert port bit
	output logic                      external_reset_active           // Pin 5 is reset input
);

	// ======================================================================
	// Override signals, one bit per pin
	logic [PIN_COUNT-1:0] pullup_override_enable;      // Pull-up taken over
	logic [PIN_COUNT-1:0] pullup_override_value;       // Pull-up forced level
	logic [PIN_COUNT-1:0] direction_override_enable;   // Driver enable taken over
	logic [PIN_COUNT-1:0] direction_override_value;    // Forced driver enable
	logic [PIN_COUNT-1:0] port_value_override_enable;  // Output value taken over
	logic [PIN_COUNT-1:0] port_value_override_value;   // Forced output value
	logic [PIN_COUNT-1:0] port_toggle_override_enable; // Port bit inversion
	logic [PIN_COUNT-1:0] input_enable_override_enable; // Input path taken over
	logic [PIN_COUNT-1:0] input_enable_override_value;  // Forced input enable

	// ======================================================================
	// Fuse terms and top pin mode
	logic                      reset_disable_prog;    // Reset disable fuse programmed
	logic                      debug_enable_prog;     // Debug fuse programmed
	logic                      clock_output_prog;     // Clock output fuse programmed
	paof_pkg::paof_pin5_mode_t pin5_mode_reg;         // Registered pin 5 role
	paof_pkg::paof_pin5_mode_t pin5_mode_next;        // Next pin 5 role
	logic                      spi_slave_active;      // SPI on as slave
	logic                      spi_master_active;     // SPI on as master
	logic                      pin_change_on;         // Pin change source armed

	// Fuses read zero when programmed, so each term compares against that level
	assign reset_disable_prog = (reset_disable_fuse == `PAOF_FUSE_PROGRAMMED);
	assign debug_enable_prog  = (debug_link_enable_fuse == `PAOF_FUSE_PROGRAMMED);
	assign clock_output_prog  = (clock_output_fuse == `PAOF_FUSE_PROGRAMMED);
	assign spi_slave_active   = spi_enable & ~spi_master;
	assign spi_master_active  = spi_enable & spi_master;
	assign pin_change_on      = pin_change_enable;

	// ======================================================================
	// Pin 5 role selection
	// Fuses are static straps; registering them keeps a glitch on the fuse
	// read path from briefly turning the reset pin into an output. During
	// reset the pin stays a reset input, which is what a held reset needs.
	always_comb begin
		// Debug link wins over the reset disable fuse
		if (debug_enable_prog && lock_bits_unprogrammed) begin
			pin5_mode_next = paof_pkg::PAOF_PIN5_DEBUG_LINK;
		end else if (reset_disable_prog) begin
			pin5_mode_next = paof_pkg::PAOF_PIN5_GENERAL_IO;
		end else begin
			pin5_mode_next = paof_pkg::PAOF_PIN5_RESET_INPUT;
		end
	end

	// Register the pin 5 role
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin5_mode_reg <= `PAOF_PIN5_MODE_RST;
		end else begin
			pin5_mode_reg <= pin5_mode_next;
		end
	end

	assign external_reset_active = (pin5_mode_reg == paof_pkg::PAOF_PIN5_RESET_INPUT);

	// ======================================================================
	// Override equations per pin
	always_comb begin
		// Defaults: no override anywhere
		pullup_override_enable       = '0;
		pullup_override_value        = '0;
		direction_override_enable    = '0;
		direction_override_value     = '0;
		port_value_override_enable   = '0;
		port_value_override_value    = '0;
		port_toggle_override_enable  = '0;
		input_enable_override_enable = '0;
		input_enable_override_value  = '0;

		// ---- Pin 5: reset, debug link or general I/O
		unique case (pin5_mode_reg)
			paof_pkg::PAOF_PIN5_RESET_INPUT: begin
				// Reset pin: pull-up on, driver and input off
				pullup_override_enable[`PAOF_PIN5]       = 1'b1;
				pullup_override_value[`PAOF_PIN5]        = 1'b1;
				direction_override_enable[`PAOF_PIN5]    = 1'b1;
				direction_override_value[`PAOF_PIN5]     = 1'b0;
				input_enable_override_enable[`PAOF_PIN5] = 1'b1;
				input_enable_override_value[`PAOF_PIN5]  = 1'b0;
			end
			paof_pkg::PAOF_PIN5_DEBUG_LINK: begin
				// Open drain: only ever drives zero, pull-up gives the high
				pullup_override_enable[`PAOF_PIN5]       = 1'b1;
				pullup_override_value[`PAOF_PIN5]        = 1'b1;
				direction_override_enable[`PAOF_PIN5]    = 1'b1;
				direction_override_value[`PAOF_PIN5]     = debug_link_transmit_low;
				port_value_override_enable[`PAOF_PIN5]   = 1'b1;
				port_value_override_value[`PAOF_PIN5]    = 1'b0;
				input_enable_override_enable[`PAOF_PIN5] = 1'b1;
				input_enable_override_value[`PAOF_PIN5]  = 1'b1;
			end
			paof_pkg::PAOF_PIN5_GENERAL_IO: begin
				// Plain I/O with analog and pin change sharing the input
				input_enable_override_enable[`PAOF_PIN5] =
					(pin_change_mask[`PAOF_PIN5] & pin_change_on) | analog_ch0_digital_disable;
				input_enable_override_value[`PAOF_PIN5]  = analog_ch0_digital_disable;
			end
		endcase

		// ---- Pin 4: oscillator, clock out, timer1 B, analog
		input_enable_override_enable[`PAOF_PIN4] =
			(pin_change_mask[`PAOF_PIN4] & pin_change_on) | analog_ch2_digital_disable;
		input_enable_override_value[`PAOF_PIN4]  = analog_ch2_digital_disable;
		if (oscillator_output_pin_used) begin
			// Oscillator owns the pad; every port path is cut
			pullup_override_enable[`PAOF_PIN4]       = 1'b1;
			direction_override_enable[`PAOF_PIN4]    = 1'b1;
			input_enable_override_enable[`PAOF_PIN4] = 1'b1;
			input_enable_override_value[`PAOF_PIN4]  = 1'b0;
		end else if (clock_output_prog) begin
			// Not gated by rst_n, so the clock keeps running during reset
			direction_override_enable[`PAOF_PIN4]  = 1'b1;
			direction_override_value[`PAOF_PIN4]   = 1'b1;
			port_value_override_enable[`PAOF_PIN4] = 1'b1;
			port_value_override_value[`PAOF_PIN4]  = divided_clock_out;
		end else if (timer1_compare_b_en) begin
			// Waveform only reaches the pad when the direction bit is set
			port_value_override_enable[`PAOF_PIN4] = 1'b1;
			port_value_override_value[`PAOF_PIN4]  = timer1_compare_b_out;
		end

		// ---- Pin 3: oscillator input, inverted timer1 B, analog
		input_enable_override_enable[`PAOF_PIN3] =
			(pin_change_mask[`PAOF_PIN3] & pin_change_on) | analog_ch3_digital_disable;
		input_enable_override_value[`PAOF_PIN3]  = analog_ch3_digital_disable;
		if (oscillator_input_pin_used) begin
			// Same isolation as the oscillator output pin
			pullup_override_enable[`PAOF_PIN3]       = 1'b1;
			direction_override_enable[`PAOF_PIN3]    = 1'b1;
			input_enable_override_enable[`PAOF_PIN3] = 1'b1;
			input_enable_override_value[`PAOF_PIN3]  = 1'b0;
		end else if (timer1_compare_b_en) begin
			port_value_override_enable[`PAOF_PIN3] = 1'b1;
			port_value_override_value[`PAOF_PIN3]  = ~timer1_compare_b_out;
		end

		// ---- Pin 2: SPI clock, two-wire clock, analog, start detector
		input_enable_override_enable[`PAOF_PIN2] =
			(pin_change_mask[`PAOF_PIN2] & pin_change_on) | analog_ch1_digital_disable
			| serial_start_interrupt_enable;
		input_enable_override_value[`PAOF_PIN2]  = analog_ch1_digital_disable;
		port_toggle_override_enable[`PAOF_PIN2]  = two_wire_clock_toggle;
		if (two_wire_mode_active) begin
			// Open drain: pull low on hold or port bit zero, else release
			pullup_override_enable[`PAOF_PIN2]     = 1'b1;
			direction_override_enable[`PAOF_PIN2]  = 1'b1;
			direction_override_value[`PAOF_PIN2]   =
				port_dir[`PAOF_PIN2] & (two_wire_clock_hold | ~port_value[`PAOF_PIN2]);
			port_value_override_enable[`PAOF_PIN2] = port_dir[`PAOF_PIN2];
			port_value_override_value[`PAOF_PIN2]  = 1'b0;
		end else if (spi_slave_active) begin
			// Forced input; the port bit still selects the pull-up
			direction_override_enable[`PAOF_PIN2] = 1'b1;
			pullup_override_enable[`PAOF_PIN2]    = 1'b1;
			pullup_override_value[`PAOF_PIN2]     =
				port_value[`PAOF_PIN2] & ~pullup_disable;
		end

		// ---- Pin 1: SPI MISO, three-wire out, timer outputs, comparator
		input_enable_override_enable[`PAOF_PIN1] =
			(pin_change_mask[`PAOF_PIN1] & pin_change_on)
			| comparator_neg_digital_disable;
		input_enable_override_value[`PAOF_PIN1]  = comparator_neg_digital_disable;
		// Waveform sources share the value path; the direction bit gates them
		port_value_override_enable[`PAOF_PIN1] = timer0_compare_b_en | timer1_compare_a_en
			| three_wire_mode_active;
		if (timer0_compare_b_en) begin
			port_value_override_value[`PAOF_PIN1] = timer0_compare_b_out;
		end else if (timer1_compare_a_en) begin
			port_value_override_value[`PAOF_PIN1] = timer1_compare_a_out;
		end else begin
			port_value_override_value[`PAOF_PIN1] = three_wire_serial_out;
		end
		if (spi_master_active) begin
			direction_override_enable[`PAOF_PIN1] = 1'b1;
			pullup_override_enable[`PAOF_PIN1]    = 1'b1;
			pullup_override_value[`PAOF_PIN1]     =
				port_value[`PAOF_PIN1] & ~pullup_disable;
		end

		// ---- Pin 0: SPI MOSI, two-wire data, reference, timer outputs
		input_enable_override_enable[`PAOF_PIN0] =
			(pin_change_mask[`PAOF_PIN0] & pin_change_on) | comparator_pos_digital_disable
			| serial_start_interrupt_enable;
		input_enable_override_value[`PAOF_PIN0]  = comparator_pos_digital_disable;
		// Three-wire input needs no override: software leaves the pin an input
		if (analog_reference_pin) begin
			// Reference voltage must never see a pull-up or a driver
			pullup_override_enable[`PAOF_PIN0]    = 1'b1;
			direction_override_enable[`PAOF_PIN0] = 1'b1;
		end else if (two_wire_mode_active) begin
			pullup_override_enable[`PAOF_PIN0]     = 1'b1;
			direction_override_enable[`PAOF_PIN0]  = 1'b1;
			direction_override_value[`PAOF_PIN0]   =
				port_dir[`PAOF_PIN0] & (~two_wire_data_out | ~port_value[`PAOF_PIN0]);
			port_value_override_enable[`PAOF_PIN0] = port_dir[`PAOF_PIN0];
			port_value_override_value[`PAOF_PIN0]  = 1'b0;
		end else if (spi_slave_active) begin
			direction_override_enable[`PAOF_PIN0] = 1'b1;
			pullup_override_enable[`PAOF_PIN0]    = 1'b1;
			pullup_override_value[`PAOF_PIN0]     =
				port_value[`PAOF_PIN0] & ~pullup_disable;
		end else if (timer0_compare_a_en) begin
			port_value_override_enable[`PAOF_PIN0] = 1'b1;
			port_value_override_value[`PAOF_PIN0]  = timer0_compare_a_out;
		end else if (timer1_compare_a_en) begin
			port_value_override_enable[`PAOF_PIN0] = 1'b1;
			port_value_override_value[`PAOF_PIN0]  = ~timer1_compare_a_out;
		end
	end

	// ======================================================================
	// Pad resolution, same for every pin
	// Kept combinational: the clock-out path has to keep toggling in reset,
	// which a reset flip-flop in front of the pad would stop.
	for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pad
		// Pull-up: override, else input pin with port bit set and no disable
		always_comb begin
			if (pullup_override_enable[i]) begin
				pad_pullup_en[i] = pullup_override_value[i];
			end else begin
				pad_pullup_en[i] = ~port_dir[i] & port_value[i] & ~pullup_disable;
			end
		end

		// Driver enable: override, else direction bit
		always_comb begin
			if (direction_override_enable[i]) begin
				pad_oe[i] = direction_override_value[i];
			end else begin
				pad_oe[i] = port_dir[i];
			end
		end

		// Output value: override, else port bit
		always_comb begin
			if (port_value_override_enable[i]) begin
				pad_out[i] = port_value_override_value[i];
			end else begin
				pad_out[i] = port_value[i];
			end
		end

		// Input enable: override, else normal or sleep state
		always_comb begin
			if (input_enable_override_enable[i]) begin
				pad_input_en[i] = input_enable_override_value[i];
			end else begin
				pad_input_en[i] = ~sleep_input_disable;
			end
		end
	end

	// Toggle requests go back to the port register, which inverts its bit
	assign port_toggle_request = port_toggle_override_enable;

endmodule // paof_port_override

// ==== tb/paof_properties.sv ====
// Concurrent checks on the pad controls of the port override block
`timescale 1ns/1ps
// ==========================================================================
// Checker
module paof_properties #(
	parameter int PIN_COUNT = 6	// Pins in the port
) (
	input wire logic                 clk, rst_n,	// Clock and reset
	input wire logic [PIN_COUNT-1:0] port_value, port_dir, pin_change_mask,
	input wire logic                 pullup_disable, sleep_input_disable,
	input wire logic                 reset_disable_fuse, debug_link_enable_fuse,
	input wire logic                 lock_bits_unprogrammed, clock_output_fuse,
	input wire logic                 divided_clock_out, debug_link_transmit_low,
	input wire logic                 oscillator_output_pin_used, spi_enable, spi_master,
	input wire logic                 two_wire_mode_active, two_wire_clock_hold,
	input wire logic                 analog_reference_pin, pin_change_enable,
	input wire logic                 analog_ch2_digital_disable, external_reset_active,
	input wire logic [PIN_COUNT-1:0] pad_pullup_en, pad_out, pad_oe, pad_input_en
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ======================================================================
	// Pin 5 role follows the fuses one edge later, since the mode is registered
	property p_reset_pin;
		external_reset_active |-> pad_pullup_en[5] && !pad_oe[5] && !pad_input_en[5];
	endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("reset pin pads wrong");
	property p_fuse_mode;
		reset_disable_fuse && debug_link_enable_fuse |=> external_reset_active;
	endproperty
	a_fuse_mode: assert property (p_fuse_mode) else $error("reset role lost");
	property p_debug;
		!debug_link_enable_fuse && lock_bits_unprogrammed |=> pad_pullup_en[5] &&
			!pad_out[5] && pad_oe[5] == debug_link_transmit_low && !external_reset_active;
	endproperty
	a_debug: assert property (p_debug) else $error("debug link pad wrong");
	// ======================================================================
	// Pin 4 clock and oscillator use
	property p_clock_out;
		!clock_output_fuse && !oscillator_output_pin_used |->
			pad_oe[4] && pad_out[4] == divided_clock_out;
	endproperty
	a_clock_out: assert property (p_clock_out) else $error("clock out missing");
	property p_osc;
		oscillator_output_pin_used |-> !pad_oe[4] && !pad_pullup_en[4] && !pad_input_en[4];
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator pin used as io");
	property p_in4;
		!oscillator_output_pin_used |-> pad_input_en[4] == ((pin_change_mask[4] &&
			pin_change_enable || analog_ch2_digital_disable) ?
			analog_ch2_digital_disable : !sleep_input_disable);
	endproperty
	a_in4: assert property (p_in4) else $error("pin 4 input enable wrong");
	// ======================================================================
	// Serial and analog overrides on pins 0 to 2
	property p_spi_slave;
		spi_enable && !spi_master && !two_wire_mode_active |-> !pad_oe[2] &&
			pad_pullup_en[2] == (port_value[2] && !pullup_disable);
	endproperty
	a_spi_slave: assert property (p_spi_slave) else $error("slave clock pin");
	property p_spi_master;
		spi_enable && spi_master |-> !pad_oe[1] &&
			pad_pullup_en[1] == (port_value[1] && !pullup_disable);
	endproperty
	a_spi_master: assert property (p_spi_master) else $error("master in pin");
	property p_analog_reference_pin;
		analog_reference_pin |-> !pad_pullup_en[0] && !pad_oe[0];
	endproperty
	a_analog_reference_pin: assert property (p_analog_reference_pin) else $error("reference pin driven");
	property p_two_wire;
		two_wire_mode_active |-> !pad_pullup_en[2] && pad_out[2] == (port_value[2] && !port_dir[2]) &&
			pad_oe[2] == (port_dir[2] && (two_wire_clock_hold || !port_value[2]));
	endproperty
	a_two_wire: assert property (p_two_wire) else $error("two-wire clock pin");
	// Main scenarios seen
	c_debug: cover property (!debug_link_enable_fuse && lock_bits_unprogrammed);
	c_clock: cover property (!clock_output_fuse && pad_oe[4]);
	c_hold: cover property (two_wire_mode_active && two_wire_clock_hold && pad_oe[2]);
endmodule // paof_properties

bind paof_port_override paof_properties #(.PIN_COUNT(PIN_COUNT)) i_chk (.*);

// ==== tb/paof_pad_model.sv ====
// Board side of the port: pad wires and the free running divided clock
`timescale 1ns/1ps
// ==========================================================================
// Pad model
module paof_pad_model (
	input wire logic       clk,	// System clock
	input wire logic [5:0] pad_pullup_en, pad_out, pad_oe,	// Pad controls
	output logic     [5:0] pad_level,	// Resolved wire level
	output logic           divided_clock_out	// Divided system clock
);
	logic alt_reg = 1'h0;	// Floating pads flip each cycle so no stale value passes
	initial divided_clock_out = 1'h0;
	// Clock divider ignores reset, as the clock must keep leaving pin 4
	always @(posedge clk) begin
		divided_clock_out <= ~divided_clock_out;
		alt_reg <= ~alt_reg;
	end
	// Driver beats pull-up, pull-up beats a floating pad; open drain shows here
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pad_level[i] = pad_oe[i] ? pad_out[i] : (pad_pullup_en[i] ? 1'h1 : alt_reg);
		end
	end
endmodule // paof_pad_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the port alternate function override block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("wrong value at %0t: note %h", $time, n); end end
module tb_top;
	// ======================================================================
	// Stimulus, notes and pads
	logic        clk = 1'h0;	// 10 MHz system clock
	logic        rst_n = 1'h0;	// Reset, low active
	logic [51:0] s = '0;	// All control inputs, one bit each
	logic [63:0] lf = 64'h2D;	// Random source state
	logic [6:0]  q[$];	// Notes: kind, pin, expected bit
	logic [6:0]  n;	// Note under comparison
	logic        g, dco, era;	// Observed bit, divided clock, reset role
	logic [5:0]  pad_pullup_en, pad_out, pad_oe, pad_input_en, port_toggle_request, pad_level;
	int          failures = 0;
	int          n_tests = 0;
	always #50 clk = ~clk;
	paof_port_override i_dut (.clk(clk), .rst_n(rst_n), .port_value(s[5:0]),
		.port_dir(s[11:6]), .pin_change_mask(s[17:12]), .pullup_disable(s[18]),
		.sleep_input_disable(s[19]), .reset_disable_fuse(s[20]),
		.debug_link_enable_fuse(s[21]), .lock_bits_unprogrammed(s[22]),
		.clock_output_fuse(s[23]), .debug_link_transmit_low(s[24]),
		.oscillator_output_pin_used(s[25]), .oscillator_input_pin_used(s[26]),
		.spi_enable(s[27]), .spi_master(s[28]), .three_wire_mode_active(s[29]),
		.three_wire_serial_out(s[30]), .two_wire_mode_active(s[31]),
		.two_wire_clock_hold(s[32]), .two_wire_data_out(s[33]),
		.two_wire_clock_toggle(s[34]), .analog_reference_pin(s[35]),
		.timer0_compare_a_en(s[36]), .timer0_compare_a_out(s[37]),
		.timer0_compare_b_en(s[38]), .timer0_compare_b_out(s[39]),
		.timer1_compare_a_en(s[40]), .timer1_compare_a_out(s[41]),
		.timer1_compare_b_en(s[42]), .timer1_compare_b_out(s[43]),
		.pin_change_enable(s[44]), .analog_ch0_digital_disable(s[45]),
		.analog_ch1_digital_disable(s[46]), .analog_ch2_digital_disable(s[47]),
		.analog_ch3_digital_disable(s[48]), .comparator_neg_digital_disable(s[49]),
		.comparator_pos_digital_disable(s[50]), .serial_start_interrupt_enable(s[51]),
		.divided_clock_out(dco), .pad_pullup_en, .pad_out, .pad_oe, .pad_input_en,
		.port_toggle_request, .external_reset_active(era));
	paof_pad_model i_pads (.clk(clk), .pad_pullup_en, .pad_out, .pad_oe, .pad_level,
		.divided_clock_out(dco));
	// ======================================================================
	// Driver: random controls with the bits under test forced, at the falling edge
	function automatic logic [63:0] lfsr_next(input logic [63:0] v);
		for (int k = 0; k < 64; k++) begin
			v = {v[62:0], v[63] ^ v[62] ^ v[60] ^ v[59]};
		end
		return v;
	endfunction
	task automatic drive(input logic [51:0] m, input logic [51:0] v);
		@(negedge clk);
		lf = lfsr_next(lf);
		s = (lf[51:0] & ~m) | (v & m);
	endtask
	task automatic ex(input int k, input int i, input logic e);
		q.push_back({k[2:0], i[2:0], e});
	endtask
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Monitor: pads are combinational, so look once they settle after the edge
	always @(posedge clk) begin
		#10;
		while (q.size() > 0) begin
			n = q.pop_front();
			case (n[6:4])
				3'h0: g = pad_pullup_en[n[3:1]];
				3'h1: g = pad_oe[n[3:1]];
				3'h2: g = pad_out[n[3:1]];
				3'h3: g = pad_input_en[n[3:1]];
				3'h4: g = era;
				3'h5: g = pad_level[n[3:1]];
				3'h6: g = port_toggle_request[n[3:1]];
				default: g = (pad_out[4] === dco);
			endcase
			`CHK(g, n[0])
		end
	end
	// ======================================================================
	// Scenarios
	initial begin
		// Held in reset: reset role on pin 5, clock still on pin 4
		drive(52'h0000002B00000, 52'h0000000300000);
		ex(0, 5, 1); ex(1, 5, 0); ex(3, 5, 0); ex(4, 0, 1); ex(1, 4, 1); ex(7, 4, 1);
		repeat (15) @(negedge clk);
		rst_n = 1'h1;
		// Reset fuse programmed: pin 5 becomes plain io
		drive(52'h0000000300000, 52'h0000000200000);
		ex(4, 0, 0); ex(1, 5, s[11]); ex(0, 5, !s[11] & s[5] & !s[18]);
		for (int i = 0; i < 2; i++) begin
			drive(52'h0000001600000, {27'h0, i[0], 24'h400000});
			ex(0, 5, 1); ex(2, 5, 0); ex(1, 5, s[24]); ex(5, 5, !s[24]); ex(4, 0, 0);
		end
		drive(52'h0000002800000, 52'h0);
		ex(1, 4, 1); ex(7, 4, 1);
		drive(52'h0000002000000, 52'h0000002000000);
		ex(1, 4, 0); ex(0, 4, 0); ex(3, 4, 0);
		drive(52'h0000898000000, 52'h0000008000000);
		ex(1, 2, 0); ex(1, 0, 0); ex(0, 2, s[2] & !s[18]); ex(1, 1, s[7]);
		drive(52'h0000898000000, 52'h0000018000000);
		ex(1, 1, 0); ex(0, 1, s[1] & !s[18]); ex(1, 2, s[8]); ex(1, 0, s[6]);
		for (int i = 0; i < 2; i++) begin
			drive(52'h00140280000C0, {44'h00000200000, i[0], 7'h0});
			ex(1, 1, s[7]); ex(1, 0, 0); ex(s[7] ? 2 : 0, 1, s[7] ? s[30] : s[1] & !s[18]);
		end
		drive(52'h0000800000040, 52'h0000800000040);
		ex(0, 0, 0); ex(1, 0, 0);
		drive(52'h0004008000080, 52'h0004000000080);
		ex(1, 1, 1); ex(2, 1, s[39]);
		for (int i = 0; i < 8; i++) begin
			drive(52'h0000006000000, 52'h0);
			ex(3, 4, (s[16] & s[44] | s[47]) ? s[47] : !s[19]);
			ex(3, 3, (s[15] & s[44] | s[48]) ? s[48] : !s[19]);
			ex(3, 2, (s[14] & s[44] | s[46] | s[51]) ? s[46] : !s[19]);
			ex(3, 1, (s[13] & s[44] | s[49]) ? s[49] : !s[19]);
			ex(0, 3, !s[9] & s[3] & !s[18]);
		end
		for (int i = 0; i < 4; i++) begin
			drive(52'h0000888000000, 52'h0000080000000);
			ex(0, 2, 0); ex(2, 2, !s[8] & s[2]); ex(1, 2, s[8] & (s[32] | !s[2])); ex(6, 2, s[34]);
			ex(1, 0, s[6] & (!s[33] | !s[0]));
		end
		repeat (2) @(posedge clk);
		complete_run();
	end
	// Watchdog: the sequence needs about forty cycles
	initial begin
		#(400 * 100);
		failures++;
		complete_run();
	end
endmodule // tb_top
